// *** hpm_pkg.sv ***
`default_nettype none
package hpm_pkg;
	// cpu-side register offsets
	localparam logic [15:0] ROUTE_ADDR = 16'h0142;
	localparam logic [15:0] DOORBELL1_ADDR = 16'h0144;
	localparam logic [15:0] DOORBELL2_ADDR = 16'h0148;
	localparam logic [15:0] MAILBOX_ADDR = 16'hC0C6;
	// reset values
	localparam logic [15:0] ROUTE_RESET = 16'h1400;
	localparam logic [15:0] MAILBOX_RESET = 16'h0000;
	// routing register bit positions
	localparam int RT_VBUS = 15;
	localparam int RT_ID = 14;
	localparam int RT_SOF2_HP = 13;
	localparam int RT_SOF2_CPU = 12;
	localparam int RT_SOF1_HP = 11;
	localparam int RT_SOF1_CPU = 10;
	localparam int RT_RST2 = 9;
	localparam int RT_SWAP_HIGH = 8;
	localparam int RT_RES2 = 7;
	localparam int RT_RES1 = 6;
	localparam int RT_DONE2 = 3;
	localparam int RT_DONE1 = 2;
	localparam int RT_RST1 = 1;
	localparam int RT_SWAP_LOW = 0;
	// status word bit positions
	localparam int ST_VBUS = 15;
	localparam int ST_ID = 14;
	localparam int ST_SOF2 = 12;
	localparam int ST_SOF1 = 10;
	localparam int ST_RST2 = 9;
	localparam int ST_MBOX_IN = 8;
	localparam int ST_RES2 = 7;
	localparam int ST_RES1 = 6;
	localparam int ST_BELL2 = 5;
	localparam int ST_BELL1 = 4;
	localparam int ST_DONE2 = 3;
	localparam int ST_DONE1 = 2;
	localparam int ST_RST1 = 1;
	localparam int ST_MBOX_OUT = 0;
	localparam int NUM_SRC = 10;

	// serial-engine interrupt levels, already gated by the engines' own enables
	typedef struct packed {
		logic vbus;
		logic id_pin;
		logic sof2;
		logic sof1;
		logic rst2;
		logic res2;
		logic res1;
		logic done2;
		logic done1;
		logic rst1;
	} hpm_src_t;

	// one access on a port: strobes are one-cycle pulses
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} hpm_acc_t;
endpackage
`default_nettype wire

// *** hpm_lane_swap.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpm_lane_swap (
	// control
	input wire logic swap_i,
	// data
	input wire logic [15:0] data_i,
	output logic [15:0] data_o
);
	assign data_o = swap_i ? {data_i[7:0], data_i[15:8]} : data_i;
endmodule // hpm_lane_swap
`default_nettype wire

// *** hpm_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpm_flag (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// events
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_o
);
	logic next_flag;
	// set wins so an event in the clearing cycle is not lost
	always_comb begin
		next_flag = flag_o;
		if (clr_i) begin
			next_flag = 1'b0;
		end
		if (set_i) begin
			next_flag = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flag_o <= 1'b0;
		end else begin
			flag_o <= next_flag;
		end
	end
endmodule // hpm_flag
`default_nettype wire

// *** hpm_host_irq_route.sv ***
// Behaviour
// R01: cpu reads routing register only; host port reads and writes it.
// R02: routing bit 1 sends an engine interrupt to host irq and status.
// R03: routing picks destination only; engine enables gate sources upstream.
// R04: bit 15 routes bus-voltage interrupt to host port, else cpu.
// R05: bit 14 routes id-pin interrupt to host port, else cpu.
// R06: bits 13 and 11 route frame events of engines 2, 1 to host.
// R07: bits 12 and 10 route frame events to cpu, independently of host.
// R08: firmware lets only one party clear a frame event routed to both.
// R09: bits 9 and 1 move reset interrupts 2 and 1 to host.
// R10: bits 7 and 6 move resume interrupts 2 and 1 to host.
// R11: bits 3 and 2 move done interrupts 2 and 1 to host.
// R12: software writes swap bits 8 and 0 with the same value.
// R13: swap 00 keeps msb on upper lanes; 11 swaps the bytes.
// R14: writes to doorbells 0x0144, 0x0148 set flags and host irq.
// R15: host port read of a doorbell clears its flag.
// R16: shared 16-bit mailbox at 0xC0C6, reset to zero.
// R17: host mailbox write fires rx-full; cpu mailbox read clears it.
// R18: host mailbox read fires tx-empty; next cpu mailbox write clears it.
// R19: cpu mailbox write asserts host irq; host mailbox read drops it.
// R20: status word is host-port only, with the fixed flag layout.
// R21: status reads make no memory access cycle.
// R22: mailbox-in clears on cpu read; mailbox-out on host read.
// R23: host irq is the or of routed sources, doorbells and mailbox-out.
`timescale 1ns/1ps
`default_nettype none
module hpm_host_irq_route (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// serial-engine interrupt levels, same clock
	input wire hpm_pkg::hpm_src_t src_i,
	// on-chip cpu register port
	input wire hpm_pkg::hpm_acc_t cpu_acc_i,
	output logic [15:0] cpu_rdata_o,
	output logic cpu_hit_o,
	// cpu interrupt requests
	output hpm_pkg::hpm_src_t cpu_irq_o,
	output logic mbox_rx_full_irq_o,
	output logic mbox_tx_empty_irq_o,
	// mailbox interrupt enables, from the cpu interrupt controller
	input wire logic mbox_rx_full_en_i,
	input wire logic mbox_tx_empty_en_i,
	// parallel host port, register and status access
	input wire hpm_pkg::hpm_acc_t host_acc_i,
	input wire logic host_status_rd_i,
	output logic [15:0] host_port_data_bus_o,
	output logic host_hit_o,
	output logic host_port_irq_out_o,
	// memory access request toward the arbiter
	output logic host_mem_req_o,
	output logic byte_lane_swap_o
);
	logic [15:0] route;
	logic [15:0] next_route;
	logic [15:0] mailbox;
	logic [15:0] next_mailbox;
	logic [15:0] status;
	logic [15:0] host_wdata;
	logic [15:0] host_rdata_raw;
	logic [15:0] host_rdata_lanes;
	logic [15:0] next_cpu_rdata;
	logic next_cpu_hit;
	logic next_host_hit;
	logic [15:0] next_host_data;
	logic next_irq;
	logic next_mem_req;
	logic [9:0] routed_host;
	logic [9:0] src_vec;
	logic [9:0] route_host_bits;
	logic bell1;
	logic bell2;
	logic mbox_in;
	logic mbox_out;
	logic rx_full;
	logic tx_empty;
	logic host_wr_mbox;
	logic host_rd_mbox;
	logic cpu_wr_mbox;
	logic cpu_rd_mbox;
	hpm_pkg::hpm_src_t next_cpu_irq;
	logic next_rx_irq;
	logic next_tx_irq;
	logic next_swap;

	function automatic logic hit(input hpm_pkg::hpm_acc_t a, input logic [15:0] off);
		hit = (a.wr | a.rd) & (a.addr == off);
	endfunction

	function automatic logic wr_hit(input hpm_pkg::hpm_acc_t a, input logic [15:0] off);
		wr_hit = a.wr & hit(a, off);
	endfunction

	function automatic logic rd_hit(input hpm_pkg::hpm_acc_t a, input logic [15:0] off);
		rd_hit = a.rd & hit(a, off);
	endfunction

	assign host_wr_mbox = wr_hit(host_acc_i, hpm_pkg::MAILBOX_ADDR);
	assign host_rd_mbox = rd_hit(host_acc_i, hpm_pkg::MAILBOX_ADDR);
	assign cpu_wr_mbox = wr_hit(cpu_acc_i, hpm_pkg::MAILBOX_ADDR);
	assign cpu_rd_mbox = rd_hit(cpu_acc_i, hpm_pkg::MAILBOX_ADDR);

	// host data arrives and leaves through the selected lane order
	hpm_lane_swap u_swap_in (
		.swap_i(byte_lane_swap_o),
		.data_i(host_acc_i.wdata),
		.data_o(host_wdata)
	); // [R13]
	hpm_lane_swap u_swap_out (
		.swap_i(byte_lane_swap_o),
		.data_i(host_rdata_raw),
		.data_o(host_rdata_lanes)
	); // [R13]

	// doorbell and mailbox flags
	hpm_flag u_bell1 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(cpu_acc_i.wr & hit(cpu_acc_i, hpm_pkg::DOORBELL1_ADDR)), // [R14]
		.clr_i(host_acc_i.rd & hit(host_acc_i, hpm_pkg::DOORBELL1_ADDR)), // [R15]
		.flag_o(bell1)
	);
	hpm_flag u_bell2 (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(cpu_acc_i.wr & hit(cpu_acc_i, hpm_pkg::DOORBELL2_ADDR)), // [R14]
		.clr_i(host_acc_i.rd & hit(host_acc_i, hpm_pkg::DOORBELL2_ADDR)), // [R15]
		.flag_o(bell2)
	);
	hpm_flag u_mbox_in (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(host_wr_mbox),
		.clr_i(cpu_rd_mbox), // [R22]
		.flag_o(mbox_in)
	);
	hpm_flag u_mbox_out (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(cpu_wr_mbox), // [R19]
		.clr_i(host_rd_mbox), // [R19] [R22]
		.flag_o(mbox_out)
	);
	hpm_flag u_rx_full (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(host_wr_mbox), // [R17]
		.clr_i(cpu_rd_mbox), // [R17]
		.flag_o(rx_full)
	);
	hpm_flag u_tx_empty (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(host_rd_mbox), // [R18]
		.clr_i(cpu_wr_mbox), // [R18]
		.flag_o(tx_empty)
	);

	// sources and their host-route bits in matching order
	assign src_vec = {src_i.vbus, src_i.id_pin, src_i.sof2, src_i.sof1, src_i.rst2,
		src_i.res2, src_i.res1, src_i.done2, src_i.done1, src_i.rst1};
	assign route_host_bits = {route[hpm_pkg::RT_VBUS], route[hpm_pkg::RT_ID],
		route[hpm_pkg::RT_SOF2_HP], route[hpm_pkg::RT_SOF1_HP], route[hpm_pkg::RT_RST2],
		route[hpm_pkg::RT_RES2], route[hpm_pkg::RT_RES1], route[hpm_pkg::RT_DONE2],
		route[hpm_pkg::RT_DONE1], route[hpm_pkg::RT_RST1]};

	// sources are already gated by the engines' enables; routing only steers
	genvar gi;
	generate
		for (gi = 0; gi < hpm_pkg::NUM_SRC; gi++) begin : g_route
			assign routed_host[gi] = src_vec[gi] & route_host_bits[gi]; // [R02] [R03]
		end
	endgenerate

	// status word, layout fixed; reserved bits 13 and 11 read zero
	always_comb begin
		status = 16'h0000;
		status[hpm_pkg::ST_VBUS] = routed_host[9]; // [R04] [R20]
		status[hpm_pkg::ST_ID] = routed_host[8]; // [R05] [R20]
		status[hpm_pkg::ST_SOF2] = routed_host[7]; // [R06] [R20]
		status[hpm_pkg::ST_SOF1] = routed_host[6]; // [R06] [R20]
		status[hpm_pkg::ST_RST2] = routed_host[5]; // [R09]
		status[hpm_pkg::ST_MBOX_IN] = mbox_in; // [R20]
		status[hpm_pkg::ST_RES2] = routed_host[4]; // [R10]
		status[hpm_pkg::ST_RES1] = routed_host[3]; // [R10]
		status[hpm_pkg::ST_BELL2] = bell2; // [R14]
		status[hpm_pkg::ST_BELL1] = bell1; // [R14]
		status[hpm_pkg::ST_DONE2] = routed_host[2]; // [R11]
		status[hpm_pkg::ST_DONE1] = routed_host[1]; // [R11]
		status[hpm_pkg::ST_RST1] = routed_host[0]; // [R09]
		status[hpm_pkg::ST_MBOX_OUT] = mbox_out; // [R20]
	end

	// register and cpu-interrupt next values
	always_comb begin
		next_route = route;
		next_mailbox = mailbox;
		// only the host port may change routing; a cpu write is ignored
		if (host_acc_i.wr & hit(host_acc_i, hpm_pkg::ROUTE_ADDR)) begin
			next_route = host_wdata; // [R01] [R12]
		end
		if (cpu_wr_mbox) begin
			next_mailbox = cpu_acc_i.wdata; // [R16]
		end
		// host write wins a same-cycle collision; the cpu sees rx-full
		if (host_wr_mbox) begin
			next_mailbox = host_wdata; // [R16]
		end
		next_cpu_irq.vbus = src_i.vbus & ~route[hpm_pkg::RT_VBUS]; // [R04]
		next_cpu_irq.id_pin = src_i.id_pin & ~route[hpm_pkg::RT_ID]; // [R05]
		next_cpu_irq.sof2 = src_i.sof2 & route[hpm_pkg::RT_SOF2_CPU]; // [R07]
		next_cpu_irq.sof1 = src_i.sof1 & route[hpm_pkg::RT_SOF1_CPU]; // [R07]
		next_cpu_irq.rst2 = src_i.rst2 & ~route[hpm_pkg::RT_RST2]; // [R09]
		next_cpu_irq.res2 = src_i.res2 & ~route[hpm_pkg::RT_RES2]; // [R10]
		next_cpu_irq.res1 = src_i.res1 & ~route[hpm_pkg::RT_RES1]; // [R10]
		next_cpu_irq.done2 = src_i.done2 & ~route[hpm_pkg::RT_DONE2]; // [R11]
		next_cpu_irq.done1 = src_i.done1 & ~route[hpm_pkg::RT_DONE1]; // [R11]
		next_cpu_irq.rst1 = src_i.rst1 & ~route[hpm_pkg::RT_RST1]; // [R09]
		next_irq = (|routed_host) | bell1 | bell2 | mbox_out; // [R23] [R19]
		// both swap bits must agree; the high copy is what steers the lanes
		next_swap = next_route[hpm_pkg::RT_SWAP_HIGH]; // [R13]
		// enables gate the outputs, not the flags, so a late enable still reports
		next_rx_irq = rx_full & mbox_rx_full_en_i; // [R17]
		next_tx_irq = tx_empty & mbox_tx_empty_en_i; // [R18]
	end

	// read paths; status is never visible to the cpu
	always_comb begin
		// a cpu doorbell read is refused: no hit and zero data
		next_cpu_hit = hit(cpu_acc_i, hpm_pkg::ROUTE_ADDR) | hit(cpu_acc_i, hpm_pkg::MAILBOX_ADDR) |
			(cpu_acc_i.wr & (hit(cpu_acc_i, hpm_pkg::DOORBELL1_ADDR) |
			hit(cpu_acc_i, hpm_pkg::DOORBELL2_ADDR)));
		next_cpu_rdata = 16'h0000;
		if (cpu_acc_i.rd & hit(cpu_acc_i, hpm_pkg::ROUTE_ADDR)) begin
			next_cpu_rdata = route; // [R01]
		end else if (cpu_rd_mbox) begin
			next_cpu_rdata = mailbox;
		end
		host_rdata_raw = 16'h0000;
		next_host_hit = hit(host_acc_i, hpm_pkg::ROUTE_ADDR) |
			hit(host_acc_i, hpm_pkg::MAILBOX_ADDR) |
			(host_acc_i.rd & (hit(host_acc_i, hpm_pkg::DOORBELL1_ADDR) |
			hit(host_acc_i, hpm_pkg::DOORBELL2_ADDR)));
		// the status word is served from flops here, not through memory
		next_mem_req = (host_acc_i.wr | host_acc_i.rd) & ~next_host_hit; // [R21]
		if (host_status_rd_i) begin
			host_rdata_raw = status; // [R20] [R21]
		end else if (host_acc_i.rd & hit(host_acc_i, hpm_pkg::ROUTE_ADDR)) begin
			host_rdata_raw = route; // [R01]
		end else if (host_rd_mbox) begin
			host_rdata_raw = mailbox;
		end
	end

	// kept outside the read process so the lane swap does not loop back into it
	assign next_host_data = host_rdata_lanes;

	// register group
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			route <= hpm_pkg::ROUTE_RESET;
			mailbox <= hpm_pkg::MAILBOX_RESET; // [R16]
			byte_lane_swap_o <= 1'b0;
		end else begin
			route <= next_route;
			mailbox <= next_mailbox;
			byte_lane_swap_o <= next_swap; // [R13]
		end
	end

	// interrupt group
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cpu_irq_o <= '0;
			host_port_irq_out_o <= 1'b0;
			mbox_rx_full_irq_o <= 1'b0;
			mbox_tx_empty_irq_o <= 1'b0;
		end else begin
			cpu_irq_o <= next_cpu_irq;
			host_port_irq_out_o <= next_irq; // [R23]
			mbox_rx_full_irq_o <= next_rx_irq; // [R17]
			mbox_tx_empty_irq_o <= next_tx_irq; // [R18]
		end
	end

	// read answers stand for one cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cpu_rdata_o <= 16'h0000;
			cpu_hit_o <= 1'b0;
			host_port_data_bus_o <= 16'h0000;
			host_hit_o <= 1'b0;
			host_mem_req_o <= 1'b0;
		end else begin
			cpu_rdata_o <= next_cpu_rdata;
			cpu_hit_o <= next_cpu_hit;
			host_port_data_bus_o <= next_host_data;
			host_hit_o <= next_host_hit;
			host_mem_req_o <= next_mem_req;
		end
	end
endmodule // hpm_host_irq_route
`default_nettype wire

// *** hpm_route_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpm_route_sva (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// accesses
	input wire hpm_pkg::hpm_acc_t cpu_acc_i,
	input wire hpm_pkg::hpm_acc_t host_acc_i,
	input wire logic host_status_rd_i,
	input wire logic mbox_rx_full_en_i,
	input wire logic mbox_tx_empty_en_i,
	// watched outputs
	input wire logic mbox_rx_full_irq_o,
	input wire logic mbox_tx_empty_irq_o,
	input wire logic host_hit_o,
	input wire logic host_port_irq_out_o,
	input wire logic host_mem_req_o,
	input wire logic byte_lane_swap_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	wire logic cmw = cpu_acc_i.wr && cpu_acc_i.addr == hpm_pkg::MAILBOX_ADDR;
	wire logic cmr = cpu_acc_i.rd && cpu_acc_i.addr == hpm_pkg::MAILBOX_ADDR;
	wire logic hmw = host_acc_i.wr && host_acc_i.addr == hpm_pkg::MAILBOX_ADDR;
	wire logic hmr = host_acc_i.rd && host_acc_i.addr == hpm_pkg::MAILBOX_ADDR;
	wire logic hrw = host_acc_i.wr && host_acc_i.addr == hpm_pkg::ROUTE_ADDR;
	wire logic bell = cpu_acc_i.wr && (cpu_acc_i.addr == hpm_pkg::DOORBELL1_ADDR
		|| cpu_acc_i.addr == hpm_pkg::DOORBELL2_ADDR);
	route_ro_a: assert property (cpu_acc_i.wr && cpu_acc_i.addr == hpm_pkg::ROUTE_ADDR
		&& !hrw |=> $stable(byte_lane_swap_o)) else $error("cpu changed routing");
	swap_set_a: assert property (hrw && !byte_lane_swap_o && host_acc_i.wdata[8]
		|=> byte_lane_swap_o) else $error("swap did not set");
	swap_clr_a: assert property (hrw && byte_lane_swap_o && !host_acc_i.wdata[0]
		|=> !byte_lane_swap_o) else $error("swap did not clear");
	bell_irq_a: assert property (bell |-> ##2 host_port_irq_out_o)
		else $error("doorbell gave no host irq");
	mbox_irq_a: assert property (cmw |-> ##2 host_port_irq_out_o)
		else $error("mailbox write gave no host irq");
	rx_full_a: assert property (hmw && mbox_rx_full_en_i ##1 (mbox_rx_full_en_i && !cmr)
		|-> ##[0:1] mbox_rx_full_irq_o) else $error("rx full missing");
	tx_empty_a: assert property (hmr && mbox_tx_empty_en_i ##1 (mbox_tx_empty_en_i && !cmw)
		|-> ##[0:1] mbox_tx_empty_irq_o) else $error("tx empty missing");
	rx_gate_a: assert property (!mbox_rx_full_en_i |=> !mbox_rx_full_irq_o)
		else $error("rx full not gated");
	stat_nomem_a: assert property (host_status_rd_i && !host_acc_i.wr && !host_acc_i.rd
		|=> !host_mem_req_o) else $error("status read hit memory");
	mbox_hit_a: assert property (hmr |=> host_hit_o && !host_mem_req_o)
		else $error("mailbox not local");
	c_bell: cover property (bell ##2 host_port_irq_out_o);
	c_mbox: cover property (hmr ##1 host_hit_o);
	c_swap: cover property (hrw ##1 byte_lane_swap_o);
endmodule // hpm_route_sva
bind hpm_host_irq_route hpm_route_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
	.cpu_acc_i(cpu_acc_i), .host_acc_i(host_acc_i), .host_status_rd_i(host_status_rd_i),
	.mbox_rx_full_en_i(mbox_rx_full_en_i), .mbox_tx_empty_en_i(mbox_tx_empty_en_i),
	.mbox_rx_full_irq_o(mbox_rx_full_irq_o), .mbox_tx_empty_irq_o(mbox_tx_empty_irq_o),
	.host_hit_o(host_hit_o), .host_port_irq_out_o(host_port_irq_out_o),
	.host_mem_req_o(host_mem_req_o), .byte_lane_swap_o(byte_lane_swap_o));
`default_nettype wire

// *** hpm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model (
	// clock
	input wire logic clk_i,
	// host port
	input wire logic [15:0] data_i,
	output hpm_pkg::hpm_acc_t acc_o,
	output logic status_rd_o
);
	initial begin
		acc_o = '0;
		status_rd_o = 1'b0;
	end
	task automatic xfer(input logic w, r, s, input logic [15:0] a, d, output logic [15:0] q);
		@(negedge clk_i);
		acc_o = '{w, r, a, d};
		status_rd_o = s;
		@(negedge clk_i);
		q = data_i;
		// released lines show the inverse so stale values cannot pass for live ones
		acc_o = '{1'b0, 1'b0, ~a, ~d};
		status_rd_o = 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, d);
		logic [15:0] q;
		xfer(1'b1, 1'b0, 1'b0, a, d, q);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		xfer(1'b0, 1'b1, 1'b0, a, 16'h0000, q);
	endtask
	// polls only; frame events are left for the cpu to clear
	task automatic st(output logic [15:0] q);
		xfer(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, q);
	endtask
	task automatic set_route(input logic [15:0] v);
		wr(hpm_pkg::ROUTE_ADDR, {v[15:1], v[8]});
	endtask
endmodule // hpm_host_model
`default_nettype wire

// *** host_port_irq_routing_mailbox_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module host_port_irq_routing_mailbox_bench;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	hpm_pkg::hpm_src_t src = '0;
	hpm_pkg::hpm_src_t cpu_irq;
	hpm_pkg::hpm_acc_t cpu_acc = '0;
	hpm_pkg::hpm_acc_t host_acc;
	logic st_rd, rx_en, tx_en, cpu_hit, host_hit, hirq, mreq, swap, rx_irq, tx_irq;
	logic [15:0] cpu_rdata, host_data, q, a;
	int n_mismatch = 0;
	int comparisons = 0;
	int rtb[10] = '{15, 14, 13, 11, 9, 7, 6, 3, 2, 1};
	int stb[10] = '{15, 14, 12, 10, 9, 7, 6, 3, 2, 1};
	always #20 clk_i = ~clk_i;
	hpm_host_irq_route uut (.clk_i(clk_i), .reset_i(reset_i), .src_i(src),
		.cpu_acc_i(cpu_acc), .cpu_rdata_o(cpu_rdata), .cpu_hit_o(cpu_hit), .cpu_irq_o(cpu_irq),
		.mbox_rx_full_irq_o(rx_irq), .mbox_tx_empty_irq_o(tx_irq), .mbox_rx_full_en_i(rx_en),
		.mbox_tx_empty_en_i(tx_en), .host_acc_i(host_acc), .host_status_rd_i(st_rd),
		.host_port_data_bus_o(host_data), .host_hit_o(host_hit), .host_port_irq_out_o(hirq),
		.host_mem_req_o(mreq), .byte_lane_swap_o(swap));
	hpm_host_model host (.clk_i(clk_i), .data_i(host_data), .acc_o(host_acc), .status_rd_o(st_rd));
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic cpu_x(input logic w, input logic [15:0] ad, d);
		@(negedge clk_i);
		cpu_acc = '{w, ~w, ad, d};
		@(negedge clk_i);
		q = cpu_rdata;
		cpu_acc = '{1'b0, 1'b0, ~ad, ~d};
	endtask
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		rx_en = 1'b1;
		tx_en = 1'b1;
		step(3);
		reset_i = 1'b0;
		cpu_x(1'b0, hpm_pkg::ROUTE_ADDR, 16'h0000);
		`CHK(q, 16'h1400)
		`CHK(cpu_hit, 1'b1)
		cpu_x(1'b0, hpm_pkg::DOORBELL1_ADDR, 16'h0000);
		`CHK(q, 16'h0000)
		`CHK(cpu_hit, 1'b0)
		cpu_x(1'b0, hpm_pkg::MAILBOX_ADDR, 16'h0000);
		`CHK(q, 16'h0000)
		cpu_x(1'b1, hpm_pkg::ROUTE_ADDR, 16'hFFFF);
		host.rd(hpm_pkg::ROUTE_ADDR, q);
		`CHK(q, 16'h1400)
		`CHK(host_hit, 1'b1)
		for (int i = 0; i < 10; i++) begin
			src = '0;
			host.wr(hpm_pkg::ROUTE_ADDR, 16'(1) << rtb[i]);
			src = hpm_pkg::hpm_src_t'(10'(1) << (9 - i));
			step(3);
			`CHK(hirq, 1'b1)
			`CHK(cpu_irq, 10'h000)
			host.st(q);
			`CHK(q, 16'(1) << stb[i])
			host.wr(hpm_pkg::ROUTE_ADDR, (i == 2 || i == 3) ? 16'(3) << (rtb[i] - 1) : 16'h0000);
			step(3);
			`CHK(hirq, i == 2 || i == 3)
			`CHK(cpu_irq, src)
		end
		src = '0;
		for (int k = 0; k < 2; k++) begin
			a = k ? hpm_pkg::DOORBELL2_ADDR : hpm_pkg::DOORBELL1_ADDR;
			cpu_x(1'b1, a, 16'h5AC3);
			step(2);
			`CHK(hirq, 1'b1)
			host.st(q);
			`CHK(q, 16'h0010 << k)
			host.rd(a, q);
			step(2);
			`CHK(hirq, 1'b0)
			host.st(q);
			`CHK(q, 16'h0000)
		end
		host.wr(hpm_pkg::MAILBOX_ADDR, 16'h1234);
		step(2);
		`CHK(rx_irq, 1'b1)
		`CHK(hirq, 1'b0)
		host.st(q);
		`CHK(q, 16'h0100)
		cpu_x(1'b0, hpm_pkg::MAILBOX_ADDR, 16'h0000);
		`CHK(q, 16'h1234)
		step(2);
		`CHK(rx_irq, 1'b0)
		cpu_x(1'b1, hpm_pkg::MAILBOX_ADDR, 16'hBEEF);
		step(2);
		`CHK(hirq, 1'b1)
		host.st(q);
		`CHK(q, 16'h0001)
		host.rd(hpm_pkg::MAILBOX_ADDR, q);
		`CHK(q, 16'hBEEF)
		step(2);
		`CHK(hirq, 1'b0)
		`CHK(tx_irq, 1'b1)
		cpu_x(1'b1, hpm_pkg::MAILBOX_ADDR, 16'h12AB);
		step(2);
		`CHK(tx_irq, 1'b0)
		rx_en = 1'b0;
		host.set_route(16'h0100);
		`CHK(swap, 1'b1)
		host.rd(hpm_pkg::MAILBOX_ADDR, q);
		`CHK(q, 16'hAB12)
		tx_en = 1'b0;
		host.wr(hpm_pkg::MAILBOX_ADDR, 16'h3456);
		`CHK(tx_irq, 1'b0)
		cpu_x(1'b0, hpm_pkg::MAILBOX_ADDR, 16'h0000);
		`CHK(q, 16'h5634)
		tx_en = 1'b1;
		step(2);
		`CHK(tx_irq, 1'b1)
		host.set_route(16'h0000);
		`CHK(swap, 1'b0)
		host.wr(hpm_pkg::MAILBOX_ADDR, 16'h0001);
		step(2);
		`CHK(rx_irq, 1'b0)
		host.rd(16'h2000, q);
		`CHK(mreq, 1'b1)
		host.st(q);
		`CHK(mreq, 1'b0)
		reset_i = 1'b1;
		step(2);
		reset_i = 1'b0;
		host.rd(hpm_pkg::ROUTE_ADDR, q);
		`CHK(q, 16'h1400)
		wrap_up();
	end
endmodule // host_port_irq_routing_mailbox_bench
`default_nettype wire
